/* File: src/sadc_port.sv */
module sadc_port (
  // system clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // link pins
  input  wire logic                    sclk,
  input  wire logic                    convert_strobe,
  input  wire logic                    serial_in,
  output logic                         serial_out,
  output logic                         serial_out_oe,
  // configuration levels
  input  wire logic                    cs_on_serial_in,
  input  wire logic                    busy_enable,
  // converter core
  output logic                         power_down,
  input  wire logic                    result_valid,
  input  wire logic [sadc_pkg::RES_BITS-1:0] result_data,
  output logic                         result_ready
);
  import sadc_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0]       cnt;
    logic [CNT_W-1:0]       gray;
    logic [DAISY_DEPTH-1:0] chain;
  } sadc_lnk_t;

  typedef struct packed {
    logic [1:0]          cnv_s;
    logic [1:0]          din_s;
    logic                cnv_d;
    logic                cs_d;
    logic [CNT_W-1:0]    g_s1;
    logic [CNT_W-1:0]    g_s2;
    logic [CNT_W-1:0]    base;
    sadc_mode_t          mode;
    sadc_state_t         state;
    logic [RES_BITS-1:0] word;
    logic                active;
    logic                tail;
    logic                dout;
    logic                dout_oe;
    logic                power_down;
  } sadc_ctl_t;

  sadc_lnk_t           l;
  sadc_lnk_t           next_l;
  sadc_ctl_t           c;
  sadc_ctl_t           next_c;
  logic                buf_in_valid;
  logic                buf_in_ready;
  logic                buf_valid;
  logic [RES_BITS-1:0] buf_data;
  logic                pop;
  logic                push;
  logic                cnv_rise;
  logic                cs_level;
  logic                cs_fall;
  logic                cs_rise;
  logic [CNT_W-1:0]    cnt_now;
  logic [CNT_W-1:0]    rel;
  logic [CNT_W-1:0]    n_own;
  logic [DIDX_W-1:0]   daisy_idx;
  logic                exp_own;

  // serial bit of the own frame at a position, busy bit leading
  function automatic logic own_bit(input logic [RES_BITS-1:0] w,
                                   input logic [CNT_W-1:0]    pos,
                                   input logic                busy);
    int idx;
    idx = int'(pos);
    if (busy) begin
      own_bit = (idx == 0) ? BUSY_LEVEL : w[RES_BITS - idx];
    end else begin
      own_bit = w[RES_BITS - 1 - idx];
    end
  endfunction : own_bit

  // two-entry buffer between core and shifter
  sadc_buf #(
    .WIDTH (RES_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_buf (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (buf_in_valid),
    .in_data   (result_data),
    .in_ready  (buf_in_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (pop)
  );

  // link domain: count falls, capture upstream bits
  always_comb begin
    next_l = l;
    next_l.chain[l.cnt[DIDX_W-1:0]] = serial_in;
    next_l.cnt  = CNT_W'(l.cnt + 1'b1);
    next_l.gray = sadc_bin2gray(next_l.cnt);
  end

  // link domain register on shift-clock falling edge
  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // decoded events in the system domain
  assign cnt_now   = sadc_gray2bin(c.g_s2);
  assign rel       = CNT_W'(cnt_now - c.base);
  assign n_own     = busy_enable ? CNT_W'(RES_BITS + BUSY_BITS)
                                 : CNT_W'(RES_BITS);
  assign daisy_idx = DIDX_W'(cnt_now - n_own);
  assign cnv_rise  = c.cnv_s[1] && !c.cnv_d;
  assign cs_fall   = c.cs_d && !cs_level;
  assign cs_rise   = !c.cs_d && cs_level;
  assign buf_in_valid = result_valid && (c.state == SADC_CONV);
  assign push      = buf_in_valid && buf_in_ready;
  assign pop       = cs_fall;
  assign exp_own   = own_bit(c.word, rel, busy_enable);

  // chip select source follows the latched option
  always_comb begin
    unique case (c.mode)
      SADC_THREE: cs_level = c.cnv_s[1];
      SADC_FOUR:  cs_level = c.din_s[1];
      SADC_DAISY: cs_level = c.cnv_s[1];
      default:    cs_level = 1'b1;
    endcase
  end

  // conversion control and serial output sequencing
  always_comb begin
    next_c       = c;
    next_c.cnv_s = {c.cnv_s[0], convert_strobe};
    next_c.din_s = {c.din_s[0], serial_in};
    next_c.g_s1  = l.gray;
    next_c.g_s2  = c.g_s1;
    next_c.cnv_d = c.cnv_s[1];
    next_c.cs_d  = cs_level;
    // start on strobe rise, end on result handed to buffer
    unique case (c.state)
      SADC_ACQ: begin
        if (cnv_rise) begin
          next_c.state      = SADC_CONV;
          next_c.power_down = 1'b0;
          if (!c.din_s[1]) begin
            next_c.mode = SADC_DAISY;
          end else if (cs_on_serial_in) begin
            next_c.mode = SADC_FOUR;
          end else begin
            next_c.mode = SADC_THREE;
          end
        end
      end
      SADC_CONV: begin
        if (push) begin
          next_c.state      = SADC_ACQ;
          next_c.power_down = 1'b1;
        end
      end
    endcase
    // frame start: load word, present first bit
    if (cs_fall) begin
      if (buf_valid) begin
        next_c.word = buf_data;
      end
      next_c.base    = cnt_now;
      next_c.active  = 1'b1;
      next_c.tail    = 1'b0;
      next_c.dout_oe = 1'b1;
      next_c.dout    = own_bit(next_c.word, '0, busy_enable);
    end else if (c.active) begin
      if (c.mode != SADC_DAISY && cs_rise) begin
        next_c.active  = 1'b0;
        next_c.dout_oe = 1'b0;
      end else if (!c.tail && rel < n_own) begin
        next_c.dout = exp_own;
      end else if (c.mode == SADC_DAISY) begin
        next_c.tail = 1'b1;
        next_c.dout = l.chain[daisy_idx];
      end else begin
        next_c.active  = 1'b0;
        next_c.dout_oe = 1'b0;
      end
    end
  end

  // system domain register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      c            <= '0;
      c.cnv_s      <= '0;
      c.din_s      <= {2{SYNC_RST}};
      c.cs_d       <= SYNC_RST;
      c.mode       <= SADC_THREE;
      c.state      <= SADC_ACQ;
      c.dout       <= DOUT_RST;
      c.dout_oe    <= OE_RST;
      c.power_down <= PD_RST;
    end else begin
      c <= next_c;
    end
  end

  // outputs straight from flip-flops
  assign serial_out    = c.dout;
  assign serial_out_oe = c.dout_oe;
  assign power_down    = c.power_down;
  assign result_ready  = buf_in_ready;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_pd_after_conv: assert property (
    (c.state == SADC_CONV && push) |=> c.power_down && c.state == SADC_ACQ)
    else $error("no power down after conversion");

  a_pd_in_acq: assert property (
    (c.state == SADC_ACQ) |-> c.power_down)
    else $error("powered up during acquisition");

  a_mode_latch: assert property (
    (c.state == SADC_ACQ && cnv_rise) |=> c.mode ==
      (!$past(c.din_s[1]) ? SADC_DAISY :
       ($past(cs_on_serial_in) ? SADC_FOUR : SADC_THREE)))
    else $error("option not latched at conversion start");

  a_mode_hold: assert property (
    (c.state == SADC_CONV) |=> c.mode == $past(c.mode))
    else $error("option changed during conversion");

  a_three_start: assert property (
    (c.mode == SADC_THREE && cs_fall) |=> c.dout_oe && c.active)
    else $error("3-wire frame did not start");

  a_four_start: assert property (
    (c.mode == SADC_FOUR && cs_fall) |=> c.dout_oe ##1 c.dout_oe)
    else $error("4-wire frame did not start");

  a_msb_first: assert property (
    (cs_fall && buf_valid && !busy_enable)
      |=> c.dout == $past(buf_data[RES_BITS-1]))
    else $error("first bit is not the msb");

  a_busy_lead: assert property (
    (cs_fall && busy_enable) |=> c.dout == BUSY_LEVEL)
    else $error("busy bit missing");

  a_cs_release: assert property (
    (c.active && c.mode != SADC_DAISY && !cs_fall && cs_rise)
      |=> !c.dout_oe && !c.active)
    else $error("output not released on deselect");

  a_last_release: assert property (
    (c.active && c.mode != SADC_DAISY && !cs_fall && !cs_rise
      && rel == n_own) |=> !c.dout_oe)
    else $error("output not released after last bit");

  a_bit_order: assert property (
    (c.active && !cs_fall && !cs_rise && !c.tail && rel < n_own)
      |=> c.dout == own_bit($past(c.word), $past(rel), $past(busy_enable)))
    else $error("wrong bit shifted out");

  a_daisy_drive: assert property (
    (c.mode == SADC_DAISY && c.active && !cs_fall) |=> c.dout_oe)
    else $error("daisy output not driven");

  a_chain_cap: assert property (
    @(negedge sclk) disable iff (!rstn)
    1'b1 |=> l.chain[$past(l.cnt[DIDX_W-1:0])] == $past(serial_in))
    else $error("upstream bit not captured");

endmodule : sadc_port

/* File: src/sadc_pkg.sv */
package sadc_pkg;

  // result word and serial framing
  localparam int RES_BITS    = 16;
  localparam int BUSY_BITS   = 1;
  localparam int CNT_W       = 6;
  localparam int DAISY_DEPTH = 32;
  localparam int DIDX_W      = 5;
  localparam int FIFO_DEPTH  = 2;

  // output levels and reset values
  localparam logic BUSY_LEVEL = 1'b1;
  localparam logic DOUT_RST   = 1'b0;
  localparam logic OE_RST     = 1'b0;
  localparam logic PD_RST     = 1'b1;
  localparam logic SYNC_RST   = 1'b1;

  // conversion phase
  typedef enum logic {
    SADC_ACQ  = 1'b0,
    SADC_CONV = 1'b1
  } sadc_state_t;

  // interface option latched at each conversion start
  typedef enum logic [1:0] {
    SADC_THREE = 2'b00,
    SADC_FOUR  = 2'b01,
    SADC_DAISY = 2'b10
  } sadc_mode_t;

  // binary to gray for the bit counter crossing
  function automatic logic [CNT_W-1:0] sadc_bin2gray(
    input logic [CNT_W-1:0] b);
    sadc_bin2gray = b ^ (b >> 1);
  endfunction : sadc_bin2gray

  // gray back to binary in the system domain
  function automatic logic [CNT_W-1:0] sadc_gray2bin(
    input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b = '0;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    sadc_gray2bin = b;
  endfunction : sadc_gray2bin

endpackage : sadc_pkg

/* File: src/sadc_buf.sv */
module sadc_buf #(
  parameter int WIDTH = sadc_pkg::RES_BITS,
  parameter int DEPTH = sadc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  import sadc_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
    logic                        not_full;
    logic                        not_empty;
  } sadc_buf_st_t;

  sadc_buf_st_t s;
  sadc_buf_st_t next_s;
  logic         push;
  logic         pop;

  // wrap a pointer at the buffer depth
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  // flags are registered so full and empty need no logic after them
  assign in_ready  = s.not_full;
  assign out_valid = s.not_empty;
  assign out_data  = s.mem[s.rd];
  assign push      = in_valid && s.not_full;
  assign pop       = out_ready && s.not_empty;

  // pointer and count update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = ptr_inc(s.wr);
    end
    if (pop) begin
      next_s.rd = ptr_inc(s.rd);
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
    next_s.not_full  = (next_s.count != FULL);
    next_s.not_empty = (next_s.count != '0);
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s           <= '0;
      s.not_full  <= 1'b1;
      s.not_empty <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

endmodule : sadc_buf

/* File: bench/sadc_core_model.sv */
module sadc_core_model
  import sadc_pkg::*;
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rstn,
  // converter control
  input  wire logic                          power_down,
  input  wire logic                          result_ready,
  input  wire logic [sadc_pkg::RES_BITS-1:0] word,
  input  wire logic [7:0]                    delay,
  // result handshake
  output logic                               result_valid,
  output logic [sadc_pkg::RES_BITS-1:0]      result_data
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] cnt;

  // counts the conversion time, holds the word until it is taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt          <= 8'h00;
      result_valid <= 1'b0;
    end else if (result_valid) begin
      if (result_ready) begin
        result_valid <= 1'b0;
        cnt          <= 8'h00;
      end
    end else if (power_down) begin
      cnt <= 8'h00;
    end else if (cnt == delay) begin
      result_valid <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // bus shows junk while no word is offered
  assign result_data = result_valid ? word : ~word;
endmodule : sadc_core_model

/* File: bench/tb_top.sv */
module tb_top;
  import sadc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rstn, sclk, convert_strobe, serial_in;
  logic        cs_on_serial_in, busy_enable, serial_out, serial_out_oe;
  logic        power_down, result_valid, result_ready;
  logic [15:0] result_data, word;
  logic [7:0]  delay;
  int          err_total, n_compared;
  // pin level as the host sees it
  wire         dout_w = serial_out_oe ? serial_out : 1'bz;

  sadc_port i_sadc_port (
    .clk(clk), .rstn(rstn), .sclk(sclk), .convert_strobe(convert_strobe),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .cs_on_serial_in(cs_on_serial_in),
    .busy_enable(busy_enable), .power_down(power_down),
    .result_valid(result_valid), .result_data(result_data),
    .result_ready(result_ready));

  sadc_core_model i_sadc_core_model (
    .clk(clk), .rstn(rstn), .power_down(power_down),
    .result_ready(result_ready), .word(word), .delay(delay),
    .result_valid(result_valid), .result_data(result_data));

  // system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic give_verdict();
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s: expected %b, seen %b", nm, e, g);
    end
  endtask : chk_bit

  // bounded wait on oe (s 0) or power_down (s 1)
  task automatic wait_sig(input int s, input logic lvl, input int lim);
    logic v;
    v = s ? power_down : serial_out_oe;
    for (int k = 0; k < lim && v !== lvl; k++) begin
      @(negedge clk);
      v = s ? power_down : serial_out_oe;
    end
    chk_bit(s ? "power down" : "output enable", lvl, v);
    if (v !== lvl) give_verdict();
  endtask : wait_sig

  // 125 ns link clock, bit k sampled 75 ns after fall k
  // called after a clk fall: the half-step offset keeps every sclk fall
  // and every sample 2.5 ns or more away from a rising clk edge, so the
  // upstream bit and serial_out never race the edge that samples them
  task automatic shift(input logic [31:0] e, input int n,
                       input logic [31:0] din);
    realtime t;
    t = $realtime + 52.5;
    for (int k = 0; k < n; k++) begin
      @(posedge clk) serial_in <= din[31-k];
      #(t - $realtime);
      sclk = 1'b0;
      #62.5 sclk = 1'b1;
      #12.5 chk_bit("serial out", e[31-k], dout_w);
      t = t + 125.0;
    end
  endtask : shift

  // md 0 three-wire, 1 four-wire, 2 daisy
  task automatic frame(input int md, input logic [31:0] e, input int n,
                       input logic [31:0] din);
    @(posedge clk);
    if (md == 1)
      serial_in <= 1'b0;
    else
      convert_strobe <= 1'b0;
    wait_sig(0, 1'b1, 8);
    shift(e, n, din);
    if (md != 2)
      wait_sig(0, 1'b0, 8);
    @(posedge clk) serial_in <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : frame

  task automatic convert(input logic si, input logic cs4, input logic bz,
                         input logic [15:0] w, input logic [7:0] d,
                         input bit stall);
    @(posedge clk);
    serial_in       <= si;
    cs_on_serial_in <= cs4;
    busy_enable     <= bz;
    word            <= w;
    delay           <= d;
    repeat (2) @(posedge clk);
    convert_strobe <= 1'b1;
    wait_sig(1, 1'b0, 8);
    if (stall) begin
      repeat (30) @(negedge clk);
      chk_bit("power down", 1'b0, power_down);
    end else begin
      wait_sig(1, 1'b1, 40);
      repeat (12) @(negedge clk);
      chk_bit("power down", 1'b1, power_down);
    end
    @(posedge clk);
    if (cs4)
      convert_strobe <= 1'b0;
  endtask : convert

  task automatic s_three();
    convert(1'b1, 1'b0, 1'b0, 16'ha5c3, 8'h04, 1'b0);
    frame(0, {16'ha5c3, 16'h0000}, 16, 32'h0);
  endtask : s_three

  // strobe rise cuts a busy frame and starts the next conversion
  task automatic s_abort();
    convert(1'b1, 1'b0, 1'b1, 16'h3c5a, 8'h06, 1'b0);
    @(posedge clk) convert_strobe <= 1'b0;
    wait_sig(0, 1'b1, 8);
    shift({1'b1, 16'h3c5a, 15'h0000}, 5, 32'hffffffff);
    @(posedge clk);
    word           <= 16'h0ff1;
    convert_strobe <= 1'b1;
    wait_sig(0, 1'b0, 8);
    wait_sig(1, 1'b0, 8);
    wait_sig(1, 1'b1, 40);
    frame(0, {1'b1, 16'h0ff1, 15'h0000}, 17, 32'h0);
  endtask : s_abort

  task automatic s_four();
    convert(1'b1, 1'b1, 1'b0, 16'h8001, 8'h05, 1'b0);
    repeat (6) @(negedge clk);
    chk_bit("output enable", 1'b0, serial_out_oe);
    frame(1, {16'h8001, 16'h0000}, 16, 32'h0);
  endtask : s_four

  // two unread words fill the buffer, a third conversion stalls
  task automatic s_fill();
    convert(1'b1, 1'b1, 1'b0, 16'h1234, 8'h03, 1'b0);
    chk_bit("result ready", 1'b1, result_ready);
    convert(1'b1, 1'b1, 1'b0, 16'hfedc, 8'h03, 1'b0);
    chk_bit("result ready", 1'b0, result_ready);
    convert(1'b1, 1'b1, 1'b0, 16'h5a5a, 8'h03, 1'b1);
    frame(1, {16'h1234, 16'h0000}, 16, 32'h0);
    wait_sig(1, 1'b1, 10);
    frame(1, {16'hfedc, 16'h0000}, 16, 32'h0);
    frame(1, {16'h5a5a, 16'h0000}, 16, 32'h0);
    frame(1, {16'h5a5a, 16'h0000}, 16, 32'h0);
  endtask : s_fill

  task automatic s_daisy();
    convert(1'b0, 1'b0, 1'b1, 16'hc3a5, 8'h04, 1'b0);
    frame(2, {1'b1, 16'hc3a5, 8'hd6, 7'h00}, 25,
          {8'hd6, 24'h0});
  endtask : s_daisy

  // main sequence
  initial begin
    rstn            = 1'b0;
    sclk            = 1'b1;
    convert_strobe  = 1'b0;
    serial_in       = 1'b1;
    cs_on_serial_in = 1'b0;
    busy_enable     = 1'b0;
    word            = 16'h0000;
    delay           = 8'h04;
    err_total       = 0;
    n_compared      = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    s_three();
    s_abort();
    s_four();
    s_fill();
    s_daisy();
    @(posedge clk) rstn <= 1'b0;
    @(negedge clk);
    chk_bit("output enable", 1'b0, serial_out_oe);
    chk_bit("power down", 1'b1, power_down);
    chk_bit("result ready", 1'b1, result_ready);
    give_verdict();
  end
endmodule : tb_top
